// >>> iicm_cfg.svh
// iicm_cfg.svh - timing counts and reset values for the two-wire bus master
// assumes the block clock runs at 125 MHz
`ifndef IICM_CFG_SVH
`define IICM_CFG_SVH
`define IICM_CLK_MHZ       125
`define IICM_MAX_KBPS      400
// quarter bit period in cycles, rounded up so the rate never exceeds the ceiling
`define IICM_QTR_CYC       ((`IICM_CLK_MHZ * 1000 + 4 * `IICM_MAX_KBPS - 1) / (4 * `IICM_MAX_KBPS))
`define IICM_DATA_RST      8'h00
`endif

// >>> iicm_pkg.sv
// iicm_pkg.sv - types shared by the two-wire bus master
// assumes iicm_cfg.svh holds the numeric constants
package iicm_pkg;
  typedef enum {ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_STOP, ST_RESTART} iicm_state_type;
endpackage : iicm_pkg

// >>> iicm_master.sv
// iicm_master.sv - byte-transmit two-wire bus master with start, restart and stop
// assumes open-drain pads outside; control bits come from plain ports
`timescale 1ns/10ps
`include "iicm_cfg.svh"

module iicm_master #(
  parameter int QTR_CYC = `IICM_QTR_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       controller_enable_bit_i,
  input  wire logic       transmit_irq_enable_i,
  input  wire logic       data_wr_i,
  input  wire logic [7:0] data_i,
  input  wire logic       start_set_i,
  input  wire logic       stop_set_i,
  input  wire logic       nack_clr_i,
  input  wire logic       sda_i,
  input  wire logic       scl_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic            scl_o,
  output logic            scl_oe_n_o,
  output logic            tx_data_empty_flag_o,
  output logic            start_bit_o,
  output logic            stop_bit_o,
  output logic            not_ack_interrupt_o,
  output logic            irq_o,
  output logic            busy_o
);
  import iicm_pkg::*;

  // the quarter-bit timer counts in 16 bits
  if (QTR_CYC < 1 || QTR_CYC > 65535) begin : g_bad_qtr_cyc
    $error("QTR_CYC out of range");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] sda_sync_q;
  logic [1:0] scl_sync_q;
  // both lines idle high, so reset to one to avoid a false edge

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_sync_q <= {scl_sync_q[0], scl_i};
    end
  end

  wire sda_s = sda_sync_q[1];
  wire scl_s = scl_sync_q[1];

  // ------------------------------------------------------------
  // quarter-bit timer
  // ------------------------------------------------------------
  logic [15:0]    tick_cnt_q;
  logic [1:0]     phase_q;
  iicm_state_type state_q;
  wire            run   = (state_q != ST_IDLE);
  // tick marks the end of one quarter bit
  wire            tick  = run && (tick_cnt_q == 16'(QTR_CYC - 1));
  // hold the timer while a slave stretches scl low in the high half;
  // our own release also reads low here until it passes the synchroniser
  wire            stall = phase_q[1] && !scl_s && scl_oe_n_o;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= 16'h0000;
    end else if (!run || tick) begin
      tick_cnt_q <= 16'h0000;
    end else if (!stall) begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // control bits and data register
  // ------------------------------------------------------------
  logic [7:0] data_q;
  logic [7:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic       load_evt;
  logic       start_done;
  logic       stop_done;
  logic       nack_evt;

  // the internal load wins over a write in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_q               <= `IICM_DATA_RST;
      tx_data_empty_flag_o <= 1'b1;
    end else if (load_evt) begin
      tx_data_empty_flag_o <= 1'b1;
    end else if (data_wr_i) begin
      data_q               <= data_i;
      tx_data_empty_flag_o <= 1'b0;
    end
  end

  // start and stop requests; a set on the same edge as done wins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_bit_o <= 1'b0;
      stop_bit_o  <= 1'b0;
    end else begin
      if (start_set_i && controller_enable_bit_i) begin
        start_bit_o <= 1'b1;
      end else if (start_done) begin
        start_bit_o <= 1'b0;
      end
      if (stop_set_i && controller_enable_bit_i) begin
        stop_bit_o <= 1'b1;
      end else if (stop_done) begin
        stop_bit_o <= 1'b0;
      end
    end
  end

  // sticky until software clears it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      not_ack_interrupt_o <= 1'b0;
    end else if (nack_evt) begin
      not_ack_interrupt_o <= 1'b1; // set wins over clear
    end else if (nack_clr_i) begin
      not_ack_interrupt_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= controller_enable_bit_i && ((transmit_irq_enable_i && tx_data_empty_flag_o)
               || not_ack_interrupt_o);
    end
  end

  // ------------------------------------------------------------
  // bus sequencer: phases 0..3 per bit, scl high in phases 2 and 3
  // ------------------------------------------------------------
  // q0 sets sda while scl is low, q1 releases scl, q2 is the high half
  // in which a slave may stretch and the ack is sampled, q3 pulls scl
  // low again and moves on
  // a restart releases both lines, rests in idle for one cycle and
  // re-enters the start state, which sends the repeated start
  logic sda_drv_q;
  logic scl_drv_q;
  logic ack_q;

  always_comb begin
    load_evt   = tick && phase_q == 2'h0 && state_q == ST_BIT && bit_cnt_q == 3'h6;
    // the start bit clears once the start or restart condition is on the bus
    start_done = tick && phase_q == 2'h3 && state_q == ST_START;
    stop_done  = tick && phase_q == 2'h3 && state_q == ST_STOP;
    nack_evt   = tick && phase_q == 2'h3 && state_q == ST_ACK && ack_q
                 && !start_bit_o && !stop_bit_o;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= ST_IDLE;
      phase_q   <= 2'h0;
      shift_q   <= 8'h00;
      bit_cnt_q <= 3'h0;
      ack_q     <= 1'b0;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
    end else if (!controller_enable_bit_i) begin
      state_q   <= ST_IDLE;
      phase_q   <= 2'h0;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      // only a master start is honoured; bus addresses are never decoded
      // a start waits until a byte sits in the data register
      if (start_bit_o && !tx_data_empty_flag_o) begin
        state_q <= ST_START;
        phase_q <= 2'h0;
      end
    end else if (tick) begin
      phase_q <= phase_q + 2'h1;
      case (state_q)
        ST_START: begin
          case (phase_q)
            2'h1: sda_drv_q <= 1'b1; // start: sda falls with scl high
            2'h3: begin
              scl_drv_q <= 1'b1;
              shift_q   <= data_q;
              bit_cnt_q <= 3'h7;
              state_q   <= ST_BIT;
            end
            default: ;
          endcase
        end
        ST_BIT: begin
          case (phase_q)
            2'h0: sda_drv_q <= !shift_q[7];
            2'h1: scl_drv_q <= 1'b0;
            2'h3: begin
              scl_drv_q <= 1'b1;
              shift_q   <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q - 3'h1;
              if (bit_cnt_q == 3'h0) begin
                state_q <= ST_ACK;
              end
            end
            default: ;
          endcase
        end
        ST_ACK: begin
          case (phase_q)
            2'h0: sda_drv_q <= 1'b0;
            2'h1: scl_drv_q <= 1'b0;
            2'h2: ack_q <= sda_s;
            2'h3: begin
              scl_drv_q <= 1'b1;
              if (stop_bit_o) begin
                state_q <= ST_STOP;
              end else if (start_bit_o) begin
                state_q <= ST_RESTART;
              end else if (!tx_data_empty_flag_o) begin
                shift_q   <= data_q;
                bit_cnt_q <= 3'h7;
                state_q   <= ST_BIT;
              end else begin
                // nothing queued and no request: close the bus with a stop
                state_q <= ST_STOP;
              end
            end
            default: ;
          endcase
        end
        ST_STOP: begin
          case (phase_q)
            2'h0: sda_drv_q <= 1'b1;
            2'h1: scl_drv_q <= 1'b0;
            // sda rises while scl is high: the stop condition
            2'h2: sda_drv_q <= 1'b0;
            2'h3: state_q <= ST_IDLE;
            default: ;
          endcase
        end
        // phases 2 and 3 leave both lines high ahead of the repeated start
        ST_RESTART: begin
          case (phase_q)
            2'h0: sda_drv_q <= 1'b0;
            2'h1: scl_drv_q <= 1'b0;
            2'h3: state_q <= ST_IDLE;
            default: ;
          endcase
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // open-drain pins: value always low, enable low while pulling
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= 1'b1;
      scl_o      <= 1'b0;
      scl_oe_n_o <= 1'b1;
      busy_o     <= 1'b0;
    end else begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= !sda_drv_q;
      scl_o      <= 1'b0;
      scl_oe_n_o <= !scl_drv_q;
      // busy follows the sequencer one cycle late
      busy_o     <= run;
    end
  end
endmodule : iicm_master

// >>> iicm_master_chk.sv
// iicm_master_chk.sv - port assertions for the two-wire bus master
// assumes it is bound to iicm_master and sees only its ports
`timescale 1ns/10ps
module iicm_master_chk #(
  parameter int QTR_CYC = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic controller_enable_bit_i,
  input wire logic transmit_irq_enable_i,
  input wire logic data_wr_i,
  input wire logic start_set_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic scl_o,
  input wire logic scl_oe_n_o,
  input wire logic tx_data_empty_flag_o,
  input wire logic start_bit_o,
  input wire logic stop_bit_o,
  input wire logic not_ack_interrupt_o,
  input wire logic irq_o,
  input wire logic busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  pins_low_a: assert property (!sda_o && !scl_o)
    else $error("bus pin driven high");
  idle_release_a: assert property (!busy_o |-> sda_oe_n_o && scl_oe_n_o)
    else $error("pin held while idle");
  scl_low_a: assert property ($fell(scl_oe_n_o) |=> !scl_oe_n_o [*3])
    else $error("clock low phase too short");
  irq_map_a: assert property (irq_o == $past(controller_enable_bit_i &&
    ((transmit_irq_enable_i && tx_data_empty_flag_o) || not_ack_interrupt_o)))
    else $error("irq does not follow its sources");
  wr_fills_a: assert property (data_wr_i && !busy_o |=> !tx_data_empty_flag_o)
    else $error("write left register empty");
  start_cause_a: assert property ($rose(busy_o) |-> $past(start_bit_o))
    else $error("transfer began without start bit");
  no_start_a: assert property (!controller_enable_bit_i && !start_bit_o |=> !start_bit_o)
    else $error("start taken while disabled");
  nack_quiet_a: assert property ($rose(not_ack_interrupt_o) |->
    !$past(stop_bit_o) && !$past(start_bit_o))
    else $error("nack raised with request pending");
  stop_done_a: assert property ($fell(stop_bit_o) |-> ##[0:1] (sda_oe_n_o && scl_oe_n_o))
    else $error("stop bit cleared before stop");
  empty_late_a: assert property ($rose(tx_data_empty_flag_o) |-> busy_o)
    else $error("empty rose outside a transfer");
  cover property ($fell(stop_bit_o));
  cover property ($rose(not_ack_interrupt_o));
  cover property ($rose(tx_data_empty_flag_o));
  cover property ($fell(busy_o) ##1 $rose(busy_o));
endmodule : iicm_master_chk

bind iicm_master iicm_master_chk #(.QTR_CYC(QTR_CYC)) i_chk (
  .core_clk_i              (core_clk_i),
  .rst_i                   (rst_i),
  .controller_enable_bit_i (controller_enable_bit_i),
  .transmit_irq_enable_i   (transmit_irq_enable_i),
  .data_wr_i               (data_wr_i),
  .start_set_i             (start_set_i),
  .sda_o                   (sda_o),
  .sda_oe_n_o              (sda_oe_n_o),
  .scl_o                   (scl_o),
  .scl_oe_n_o              (scl_oe_n_o),
  .tx_data_empty_flag_o    (tx_data_empty_flag_o),
  .start_bit_o             (start_bit_o),
  .stop_bit_o              (stop_bit_o),
  .not_ack_interrupt_o     (not_ack_interrupt_o),
  .irq_o                   (irq_o),
  .busy_o                  (busy_o)
);

// >>> iicm_slave_model.sv
// iicm_slave_model.sv - slave on the two-wire bus that takes every byte with no address match, write direction
// assumes the bench resolves wire levels with pull-ups
`timescale 1ns/10ps
module iicm_slave_model (
  input  wire logic        sda_i,
  input  wire logic        scl_i,
  input  wire logic        ack_en_i,
  output logic             sda_pull_o,
  output logic [15:0]      bytes_o
);
  int         cnt;
  logic [7:0] sh;
  initial begin
    cnt = 0;
    sh = 8'h00;
    sda_pull_o = 1'b0;
    bytes_o = 16'h0000;
  end
  always @(negedge sda_i) begin
    if (scl_i) cnt = 0;
  end
  always @(posedge scl_i) begin
    sh = {sh[6:0], sda_i};
    if (cnt == 7) bytes_o = {bytes_o[7:0], sh};
    cnt = cnt + 1;
  end
  // pull data low through the ack slot only
  always @(negedge scl_i) begin
    sda_pull_o = (cnt == 8) && ack_en_i;
    if (cnt == 9) cnt = 0;
  end
endmodule : iicm_slave_model

// >>> tb.sv
// tb.sv - self-checking bench for the two-wire bus master
// assumes pull-ups on both bus lines and a short quarter-bit count
`timescale 1ns/10ps
module tb;
  import iicm_pkg::*;
  logic core_clk_i = 1'b0, rst_i, controller_enable_bit_i, transmit_irq_enable_i, data_wr_i;
  logic [7:0] data_i;
  logic start_set_i, stop_set_i, nack_clr_i, ack_en, sda_pull;
  logic sda_o, sda_oe_n_o, scl_o, scl_oe_n_o, tx_data_empty_flag_o;
  logic start_bit_o, stop_bit_o, not_ack_interrupt_o, irq_o, busy_o;
  logic [15:0] slv;
  int bad_count = 0, compares = 0;
  wire logic sda_i = sda_oe_n_o & ~sda_pull;
  wire logic scl_i = scl_oe_n_o;
  logic [16:0] rows [3] = '{{1'b1, 8'hA0, 8'h5C}, {1'b0, 8'hF6, 8'h3B}, {1'b1, 8'hF0, 8'h81}};
  iicm_master #(.QTR_CYC(2)) i_dut (
    .core_clk_i              (core_clk_i),
    .rst_i                   (rst_i),
    .controller_enable_bit_i (controller_enable_bit_i),
    .transmit_irq_enable_i   (transmit_irq_enable_i),
    .data_wr_i               (data_wr_i),
    .data_i                  (data_i),
    .start_set_i             (start_set_i),
    .stop_set_i              (stop_set_i),
    .nack_clr_i              (nack_clr_i),
    .sda_i                   (sda_i),
    .scl_i                   (scl_i),
    .sda_o                   (sda_o),
    .sda_oe_n_o              (sda_oe_n_o),
    .scl_o                   (scl_o),
    .scl_oe_n_o              (scl_oe_n_o),
    .tx_data_empty_flag_o    (tx_data_empty_flag_o),
    .start_bit_o             (start_bit_o),
    .stop_bit_o              (stop_bit_o),
    .not_ack_interrupt_o     (not_ack_interrupt_o),
    .irq_o                   (irq_o),
    .busy_o                  (busy_o)
  );
  iicm_slave_model i_slv (.sda_i(sda_i), .scl_i(scl_i), .ack_en_i(ack_en),
    .sda_pull_o(sda_pull), .bytes_o(slv));
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input logic want_empty);
    for (int n = 0; n < 2000; n++) begin
      @(posedge core_clk_i);
      #1;
      if (want_empty ? tx_data_empty_flag_o === 1'b1 : busy_o === 1'b0) return;
    end
    bad_count++;
    give_verdict();
  endtask : wt
  task automatic wr(input logic [7:0] b);
    @(posedge core_clk_i) data_i <= b;
    data_wr_i <= 1'b1;
    @(posedge core_clk_i) data_wr_i <= 1'b0;
  endtask : wr
  task automatic ctl(input logic st, input logic sp, input logic ie);
    @(posedge core_clk_i) start_set_i <= st;
    stop_set_i <= sp;
    transmit_irq_enable_i <= ie;
    @(posedge core_clk_i) start_set_i <= 1'b0;
    stop_set_i <= 1'b0;
  endtask : ctl
  initial begin
    {rst_i, ack_en} = 2'b11;
    {controller_enable_bit_i, transmit_irq_enable_i, data_wr_i} = 3'b000;
    {start_set_i, stop_set_i, nack_clr_i, data_i} = 11'h000;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i) chk({sda_oe_n_o, scl_oe_n_o, tx_data_empty_flag_o, busy_o}, 16'hE);
    ctl(1'b1, 1'b0, 1'b0);
    @(negedge core_clk_i) chk(start_bit_o, 16'h0);
    foreach (rows[i]) begin
      @(posedge core_clk_i);
      ack_en <= 1'b1;
      controller_enable_bit_i <= 1'b1;
      ctl(1'b0, 1'b0, 1'b1);
      @(negedge core_clk_i) chk(irq_o, 16'h1);
      wr(rows[i][15:8]);
      ctl(1'b1, 1'b0, 1'b1);
      wt(1'b1);
      chk(busy_o, 16'h1);
      wr(rows[i][7:0]);
      wt(1'b1);
      ack_en <= rows[i][16];
      ctl(1'b0, 1'b1, 1'b0);
      wt(1'b0);
      chk(slv, rows[i][15:0]);
      chk({start_bit_o, stop_bit_o, not_ack_interrupt_o}, 16'h0);
    end
    // repeated start: start set again while the first byte is on the bus
    wr(8'hA4);
    ctl(1'b1, 1'b0, 1'b1);
    wt(1'b1);
    ctl(1'b1, 1'b0, 1'b1);
    wr(8'h6E);
    wt(1'b1);
    ctl(1'b0, 1'b1, 1'b0);
    wt(1'b0);
    chk(slv, 16'hA46E);
    chk({start_bit_o, stop_bit_o, not_ack_interrupt_o}, 16'h0);
    ack_en <= 1'b0;
    wr(8'h55);
    ctl(1'b1, 1'b0, 1'b1);
    wt(1'b1);
    wt(1'b0);
    chk({not_ack_interrupt_o, irq_o}, 16'h3);
    @(posedge core_clk_i) nack_clr_i <= 1'b1;
    @(posedge core_clk_i) nack_clr_i <= 1'b0;
    ctl(1'b0, 1'b0, 1'b0);
    @(negedge core_clk_i) chk({not_ack_interrupt_o, irq_o}, 16'h0);
    // reset in the middle of a byte releases the bus and ends the transfer
    wr(8'hA0);
    ctl(1'b1, 1'b0, 1'b0);
    wt(1'b1);
    @(posedge core_clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i) chk({sda_oe_n_o, scl_oe_n_o, tx_data_empty_flag_o, busy_o, start_bit_o}, 16'h1C);
    give_verdict();
  end
endmodule : tb
